// ---- core/tpc_map.svh ----
// register offsets, reset values and field positions of the period/compare register set
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH

// ****************************************
// byte offsets on the peripheral bus
// ****************************************
`define TPC_TEMP_OFS 6'h0f
`define TPC_VALID_OFS 6'h06
`define TPC_TOP_OFS 6'h26
`define TPC_CMP_OFS 6'h28
`define TPC_STAGE_TOP_OFS 6'h36
`define TPC_STAGE_CMP_OFS 6'h38
`define TPC_CHAN_STRIDE 6'h02

// ****************************************
// reset values
// ****************************************
`define TPC_TOP_RST 16'hffff
`define TPC_STAGE_TOP_RST 16'hffff
`define TPC_CMP_RST 16'h0000
`define TPC_STAGE_CMP_RST 16'h0000
`define TPC_TEMP_RST 8'h00

// ****************************************
// field positions in the buffer valid control byte
// ****************************************
`define TPC_TOP_VALID_BIT 0
`define TPC_CMP_VALID_LSB 1

`endif

// ---- core/tpc_pkg.sv ----
// shared types of the period/compare register set
package tpc_pkg;
    localparam int NUM_CHAN = 3;
    typedef logic [15:0] word_t;
    typedef logic [7:0] byte_t;
    typedef logic [5:0] addr_t;
endpackage

// ---- core/tpc_chan_if.sv ----
// signals between the register set and one compare channel
`timescale 1ns/1ns
`default_nettype none
interface tpc_chan_if;
    logic wr_cmp;
    logic wr_stage;
    logic update;
    tpc_pkg::word_t wdata;
    tpc_pkg::word_t counter;
    tpc_pkg::word_t cmp;
    tpc_pkg::word_t stage;
    logic valid;
    logic match;
    modport ctl (
        output wr_cmp, wr_stage, update, wdata, counter,
        input cmp, stage, valid, match
    );
    modport chan (
        input wr_cmp, wr_stage, update, wdata, counter,
        output cmp, stage, valid, match
    );
endinterface
`default_nettype wire

// ---- core/compare_channel.sv ----
// one compare channel: active compare value, staged copy, valid flag, match detect
`include "tpc_map.svh"
`timescale 1ns/1ns
`default_nettype none
module compare_channel (
    input wire logic sys_clk,
    input wire logic reset,
    tpc_chan_if.chan ch
);
    tpc_pkg::word_t cmp_r, cmp_nxt;
    tpc_pkg::word_t stage_r, stage_nxt;
    logic valid_r, valid_nxt;
    logic match_r, match_nxt;

    // next state; a processor write beats the internal update on the same register
    always_comb begin
        cmp_nxt = cmp_r;
        if (ch.wr_cmp) begin
            cmp_nxt = ch.wdata;
        end else if (ch.update && valid_r) begin
            cmp_nxt = stage_r; // R05 R11
        end
        stage_nxt = ch.wr_stage ? ch.wdata : stage_r;
        valid_nxt = valid_r;
        if (ch.wr_stage) begin
            valid_nxt = 1'b1; // R09
        end else if (ch.update) begin
            valid_nxt = 1'b0; // R08
        end
        // compared every clock, not only at events
        match_nxt = (ch.counter == cmp_r); // R03
    end

    // registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cmp_r <= `TPC_CMP_RST;
            stage_r <= `TPC_STAGE_CMP_RST;
            valid_r <= 1'b0;
            match_r <= 1'b0;
        end else begin
            cmp_r <= cmp_nxt;
            stage_r <= stage_nxt;
            valid_r <= valid_nxt;
            match_r <= match_nxt;
        end
    end

    assign ch.cmp = cmp_r;
    assign ch.stage = stage_r;
    assign ch.valid = valid_r;
    assign ch.match = match_r;
endmodule
`default_nettype wire

// ---- core/timer_period_compare_buffers.sv ----
// period, period buffer and compare register set of a 16-bit timer, byte-wide bus
//
// Behaviour
// R01: period value is the counter top, except in frequency generation mode.
// R02: each 16-bit register is a low byte at base, high byte above.
// R03: every compare value is compared with the counter on every clock.
// R04: compare match results go out to the waveform generation logic.
// R05: on update each compare register loads from its staged compare value.
// R06: a staged top value lets a new period be written without disturbing it.
// R07: writing the staged top value sets the staged top valid bit.
// R08: an update clears all staged valid bits automatically; a staged write in the same cycle keeps its own valid bit set instead.
// R09: writing a staged compare value sets that channel's valid bit.
// R10: 16-bit values pass through one shared temporary byte, atomically.
// R11: on update, copy staged values only where their valid bit is set.
`include "tpc_map.svh"
`timescale 1ns/1ns
`default_nettype none
module timer_period_compare_buffers (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [5:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    output logic [7:0] bus_rdata,
    input wire logic [15:0] counter_value,
    input wire logic update_event,
    input wire logic frequency_generation_mode,
    output logic [15:0] top_limit,
    output logic [2:0] compare_match,
    output logic staged_top_valid,
    output logic [2:0] staged_compare_valid
);
    localparam int NC = tpc_pkg::NUM_CHAN;

    // ****************************************
    // state
    // ****************************************
    tpc_pkg::word_t top_r, top_nxt;
    tpc_pkg::word_t staged_top_r, staged_top_nxt;
    logic top_valid_r, top_valid_nxt;
    tpc_pkg::byte_t temp_r, temp_nxt;
    tpc_pkg::byte_t rdata_r, rdata_nxt;

    // bus decode and per-channel views of the compare channels
    tpc_pkg::addr_t word_addr;
    tpc_pkg::word_t wr_word;
    logic hi_wr;
    logic lo_wr;
    logic top_wr;
    logic staged_top_wr;
    tpc_pkg::word_t rd_word;
    logic rd_hit;
    tpc_pkg::byte_t status_byte;
    tpc_pkg::word_t cmp_val [NC];
    tpc_pkg::word_t stage_val [NC];
    logic [NC-1:0] cmp_hit;
    logic [NC-1:0] stage_hit;
    logic [NC-1:0] cvalid;
    logic [NC-1:0] cmatch;

    // one bundle per channel keeps strobes and views together
    tpc_chan_if ch [NC] ();

    // ****************************************
    // write decode
    // ****************************************
    // only the high-byte write commits; the low byte waits in the temporary byte
    // a lone high write therefore commits whatever the temporary byte last held
    assign word_addr = {bus_addr[5:1], 1'b0}; // R02
    assign hi_wr = bus_write && bus_addr[0];
    assign lo_wr = bus_write && !bus_addr[0];
    assign wr_word = {bus_wdata, temp_r}; // R10
    assign top_wr = hi_wr && (word_addr == `TPC_TOP_OFS);
    assign staged_top_wr = hi_wr && (word_addr == `TPC_STAGE_TOP_OFS);

    // ****************************************
    // compare channels
    // ****************************************
    generate
        for (genvar i = 0; i < NC; i++) begin : g_chan
            localparam tpc_pkg::addr_t CMP_A = 6'(`TPC_CMP_OFS + 6'(i) * `TPC_CHAN_STRIDE);
            localparam tpc_pkg::addr_t BUF_A = 6'(`TPC_STAGE_CMP_OFS + 6'(i) * `TPC_CHAN_STRIDE);
            // address hits, shared by the write strobes and the read mux
            assign cmp_hit[i] = (word_addr == CMP_A);
            assign stage_hit[i] = (word_addr == BUF_A);
            // strobes and shared data into the channel
            assign ch[i].wr_cmp = hi_wr && cmp_hit[i];
            assign ch[i].wr_stage = hi_wr && stage_hit[i];
            assign ch[i].update = update_event;
            assign ch[i].wdata = wr_word;
            assign ch[i].counter = counter_value;
            assign cmp_val[i] = ch[i].cmp;
            assign stage_val[i] = ch[i].stage;
            assign cvalid[i] = ch[i].valid;
            assign cmatch[i] = ch[i].match;
            // the channel registers its match, so it lags the counter by one clock
            compare_channel u_chan (
                .sys_clk(sys_clk),
                .reset(reset),
                .ch(ch[i])
            );
        end
    endgenerate

    // ****************************************
    // read source
    // ****************************************
    // 16-bit source of the addressed pair
    always_comb begin
        rd_word = 16'h0000;
        rd_hit = 1'b0;
        if (word_addr == `TPC_TOP_OFS) begin
            rd_word = top_r;
            rd_hit = 1'b1;
        end else if (word_addr == `TPC_STAGE_TOP_OFS) begin
            rd_word = staged_top_r;
            rd_hit = 1'b1;
        end
        // channel pairs never overlap the period pairs, so order does not matter
        for (int i = 0; i < NC; i++) begin
            if (cmp_hit[i]) begin
                rd_word = cmp_val[i];
                rd_hit = 1'b1;
            end
            if (stage_hit[i]) begin
                rd_word = stage_val[i];
                rd_hit = 1'b1;
            end
        end
    end

    // status byte: staged top valid at the bottom, one bit per channel above
    always_comb begin
        status_byte = 8'h00;
        status_byte[`TPC_TOP_VALID_BIT] = top_valid_r;
        status_byte[`TPC_CMP_VALID_LSB +: NC] = cvalid;
    end

    // ****************************************
    // period and staged period
    // ****************************************
    // a bus write to the top value beats an update in the same cycle
    always_comb begin
        top_nxt = top_r;
        if (top_wr) begin
            top_nxt = wr_word;
        end else if (update_event && top_valid_r) begin
            top_nxt = staged_top_r; // R11
        end
        staged_top_nxt = staged_top_wr ? wr_word : staged_top_r; // R06
        // set wins over clear, so a staged write racing an update is not lost
        top_valid_nxt = top_valid_r;
        if (staged_top_wr) begin
            top_valid_nxt = 1'b1; // R07
        end else if (update_event) begin
            top_valid_nxt = 1'b0; // R08
        end
    end

    // period registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            top_r <= `TPC_TOP_RST;
            staged_top_r <= `TPC_STAGE_TOP_RST;
            top_valid_r <= 1'b0;
        end else begin
            top_r <= top_nxt;
            staged_top_r <= staged_top_nxt;
            top_valid_r <= top_valid_nxt;
        end
    end

    // ****************************************
    // temporary byte and read data
    // ****************************************
    // next state of the bus side
    always_comb begin
        temp_nxt = temp_r;
        rdata_nxt = rdata_r;
        if (lo_wr && rd_hit) begin
            temp_nxt = bus_wdata; // R10
        end else if (bus_write && bus_addr == `TPC_TEMP_OFS) begin
            temp_nxt = bus_wdata;
        end
        if (bus_read) begin
            if (bus_addr == `TPC_TEMP_OFS) begin
                rdata_nxt = temp_r;
            end else if (bus_addr == `TPC_VALID_OFS) begin
                rdata_nxt = status_byte;
            end else if (rd_hit && !bus_addr[0]) begin
                // low byte read latches the high byte so the pair stays coherent
                rdata_nxt = rd_word[7:0]; // R10
                temp_nxt = rd_word[15:8];
            end else if (rd_hit) begin
                rdata_nxt = temp_r;
            end else begin
                rdata_nxt = 8'h00; // unmapped reads as zero
            end
        end
    end

    // bus side registers; read data holds until the next read
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            temp_r <= `TPC_TEMP_RST;
            rdata_r <= 8'h00;
        end else begin
            temp_r <= temp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // in frequency mode channel 0 sets the top instead of the period
    // limitation: there a compare write moves the top at once, with no staging
    assign top_limit = frequency_generation_mode ? cmp_val[0] : top_r; // R01
    assign compare_match = cmatch; // R04
    assign staged_top_valid = top_valid_r;
    assign staged_compare_valid = cvalid;
    assign bus_rdata = rdata_r;
endmodule
`default_nettype wire

// ---- tb/tpc_checker.sv ----
// port assertions for the period/compare register set
`timescale 1ns/1ns
`default_nettype none
module tpc_checker (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [5:0] bus_addr,
    input wire logic bus_write,
    input wire logic bus_read,
    input wire logic [7:0] bus_rdata,
    input wire logic [15:0] counter_value,
    input wire logic update_event,
    input wire logic frequency_generation_mode,
    input wire logic [15:0] top_limit,
    input wire logic [2:0] compare_match,
    input wire logic staged_top_valid,
    input wire logic [2:0] staged_compare_valid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // top may only move through a write, an update or a mode change
    top_hold_a: assert property (!update_event && !bus_write ##1
        $stable(frequency_generation_mode) |-> $stable(top_limit)) else $error("top moved");
    no_copy_a: assert property (update_event && !staged_top_valid && !bus_write
        && !frequency_generation_mode ##1 !frequency_generation_mode |-> $stable(top_limit))
        else $error("unstaged copy");
    top_set_a: assert property (bus_write && bus_addr == 6'h37 |=> staged_top_valid)
        else $error("top valid");
    cmp_set_a: assert property (bus_write && bus_addr == 6'h3b |=> staged_compare_valid[1])
        else $error("cmp valid");
    valid_clear_a: assert property (update_event && !bus_write |=>
        !staged_top_valid && staged_compare_valid == 3'h0) else $error("valid kept");
    rdata_hold_a: assert property (!bus_read |=> $stable(bus_rdata))
        else $error("rdata moved");
    freq_match_a: assert property (frequency_generation_mode &&
        counter_value == top_limit |=> compare_match[0]) else $error("no match");
    freq_miss_a: assert property (frequency_generation_mode &&
        counter_value != top_limit |=> !compare_match[0]) else $error("false match");
endmodule
bind timer_period_compare_buffers tpc_checker tpc_checker_inst (.*);
`default_nettype wire

// ---- tb/bus_host.sv ----
// cpu side of the byte-wide register bus
`timescale 1ns/1ns
`default_nettype none
module bus_host (
    input wire logic sys_clk,
    input wire logic [7:0] bus_rdata,
    output logic [5:0] bus_addr,
    output logic [7:0] bus_wdata,
    output logic bus_write,
    output logic bus_read
);
    // idle bus, strobes low
    initial begin
        bus_addr = 6'h00;
        bus_wdata = 8'h00;
        bus_write = 1'b0;
        bus_read = 1'b0;
    end
    // idle data inverted so stale bytes never look fresh
    task automatic wr8(input tpc_pkg::addr_t a, input tpc_pkg::byte_t d);
        @(negedge sys_clk);
        bus_addr = a;
        bus_wdata = d;
        bus_write = 1'b1;
        @(negedge sys_clk);
        bus_write = 1'b0;
        bus_wdata = ~d;
    endtask
    task automatic rd8(input tpc_pkg::addr_t a, output tpc_pkg::byte_t d);
        @(negedge sys_clk);
        bus_addr = a;
        bus_read = 1'b1;
        @(negedge sys_clk);
        bus_read = 1'b0;
        d = bus_rdata;
    endtask
    // low byte first; the low byte goes through the shared temp byte
    task automatic wr16(input tpc_pkg::addr_t a, input tpc_pkg::word_t d);
        wr8(a, d[7:0]);
        wr8(a + 6'h01, d[15:8]);
    endtask
    task automatic rd16(input tpc_pkg::addr_t a, output tpc_pkg::word_t d);
        rd8(a, d[7:0]);
        rd8(a + 6'h01, d[15:8]);
    endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the period/compare register set
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic update_event = 1'b0;
    logic frequency_generation_mode = 1'b0;
    logic [15:0] counter_value = 16'h0000;
    logic [5:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata;
    logic bus_write, bus_read, staged_top_valid;
    logic [15:0] top_limit;
    logic [2:0] compare_match, staged_compare_valid;
    int miscompares = 0;
    int cmp_count = 0;
    tpc_pkg::word_t rd;
    timer_period_compare_buffers timer_period_compare_buffers_inst (.*);
    bus_host host (.*);
    // 4 ns clock
    initial forever #2 sys_clk = ~sys_clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic upd;
        @(negedge sys_clk);
        update_event = 1'b1;
        @(negedge sys_clk);
        update_event = 1'b0;
    endtask
    task automatic t_reset;
        chk(top_limit, 16'hffff);
        chk({staged_top_valid, staged_compare_valid}, 16'h0000);
        host.rd16(6'h26, rd);
        chk(rd, 16'hffff);
        host.rd16(6'h36, rd);
        chk(rd, 16'hffff);
        host.rd16(6'h2c, rd);
        chk(rd, 16'h0000);
        host.rd8(6'h3e, rd[7:0]);
        chk(rd[7:0], 8'h00);
    endtask
    task automatic t_period;
        host.wr16(6'h26, 16'h1234);
        chk(top_limit, 16'h1234);
        host.rd16(6'h26, rd);
        chk(rd, 16'h1234);
    endtask
    task automatic t_buffer;
        host.wr16(6'h36, 16'ha5c3);
        chk(staged_top_valid, 1'b1);
        chk(top_limit, 16'h1234);
        for (int n = 0; n < tpc_pkg::NUM_CHAN; n++) begin
            host.wr16(6'h38 + 6'(2 * n), 16'h0100 + 16'(n));
            chk(staged_compare_valid[n], 1'b1);
        end
        upd;
        chk(top_limit, 16'ha5c3);
        chk({staged_top_valid, staged_compare_valid}, 16'h0000);
        for (int n = 0; n < tpc_pkg::NUM_CHAN; n++) begin
            host.rd16(6'h28 + 6'(2 * n), rd);
            chk(rd, 16'h0100 + 16'(n));
        end
        // nothing staged now, so live values must survive
        host.wr16(6'h2a, 16'h0077);
        upd;
        chk(top_limit, 16'ha5c3);
        host.rd16(6'h2a, rd);
        chk(rd, 16'h0077);
    endtask
    task automatic t_match;
        @(negedge sys_clk);
        frequency_generation_mode = 1'b1;
        counter_value = 16'h0100;
        @(negedge sys_clk);
        chk(top_limit, 16'h0100);
        chk(compare_match, 3'h1);
        counter_value = 16'h0102;
        @(negedge sys_clk);
        chk(compare_match, 3'h4);
        frequency_generation_mode = 1'b0;
        @(negedge sys_clk);
        chk(top_limit, 16'ha5c3);
    endtask
    task automatic t_status;
        host.wr16(6'h3a, 16'h0055);
        host.wr16(6'h36, 16'h2211);
        host.rd8(6'h06, rd[7:0]);
        chk(rd[7:0], 8'h05);
        host.wr8(6'h0f, 8'h9e);
        host.rd8(6'h0f, rd[7:0]);
        chk(rd[7:0], 8'h9e);
        // a lone high write commits whatever the temporary byte holds
        host.wr8(6'h27, 8'h4d);
        chk(top_limit, 16'h4d9e);
        // staged write racing an update: old staged value moves, valid stays set
        host.wr8(6'h36, 8'h44);
        fork
            host.wr8(6'h37, 8'h33);
            upd;
        join
        chk(top_limit, 16'h2211);
        chk(staged_top_valid, 1'b1);
        host.rd16(6'h2a, rd);
        chk(rd, 16'h0055);
        // a bus write to the top value beats the update of the same edge
        fork
            host.wr8(6'h27, 8'h5a);
            upd;
        join
        chk(top_limit, 16'h5a00);
        chk(staged_top_valid, 1'b0);
    endtask
    task automatic t_rereset;
        host.wr8(6'h0f, 8'hc3);
        host.rd8(6'h0f, rd[7:0]);
        chk(rd[7:0], 8'hc3);
        @(negedge sys_clk);
        reset = 1'b1;
        repeat (4) @(negedge sys_clk);
        reset = 1'b0;
        chk(top_limit, 16'hffff);
        chk({staged_top_valid, staged_compare_valid}, 16'h0000);
        chk(compare_match, 3'h0);
        chk(bus_rdata, 8'h00);
        host.rd8(6'h0f, rd[7:0]);
        chk(rd[7:0], 8'h00);
        host.rd16(6'h36, rd);
        chk(rd, 16'hffff);
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (4) @(negedge sys_clk);
        reset = 1'b0;
        t_reset;
        t_period;
        t_buffer;
        t_match;
        t_status;
        t_rereset;
        wrap_up;
    end
    // watchdog, far beyond the roughly 110 cycles needed
    initial begin
        #20000;
        miscompares++;
        wrap_up;
    end
endmodule
`default_nettype wire
